// *** fsp_pkg.sv ***
/*
  Constants shared by the framed serial sample port: word length, shift clock
  division and sampling points, and result buffer depth.
  Assumes a 25 MHz system clock; the shift clock division and sample phase derive from it.
*/
`default_nettype none

package fsp_pkg;

  // System clock period and wanted shift clock period, in ns
  localparam int FSP_CLK_PERIOD_NS = 40;
  localparam int FSP_SCLK_PERIOD_NS = 320;

  // System clocks per shift clock period, and per half period
  localparam int FSP_SCLK_DIV = FSP_SCLK_PERIOD_NS / FSP_CLK_PERIOD_NS;
  localparam int FSP_SCLK_HALF = FSP_SCLK_DIV / 2;

  // Divider phase at which synchronised inputs are sampled (mid low phase)
  localparam int FSP_SAMPLE_PHASE = FSP_SCLK_HALF + 1;

  // Bits per serial word
  localparam int FSP_WORD_BITS = 16;

  // Result buffer depth in words
  localparam int FSP_FIFO_DEPTH = 4;

  // Transmit sequencer states
  typedef enum logic [1:0] {
    FSP_TX_IDLE = 2'b00,
    FSP_TX_SYNC = 2'b01,
    FSP_TX_SHIFT = 2'b10
  } fsp_tx_state_t;

endpackage : fsp_pkg

`default_nettype wire

// *** fsp_fifo.sv ***
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
*/
`default_nettype none

module fsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW:0] wr_ptr;  // Write pointer, extra wrap bit
  logic [AW:0] rd_ptr;  // Read pointer, extra wrap bit
  logic push;  // Word accepted
  logic pop;  // Word delivered
  logic full;
  logic empty;

  // Full when pointers differ only in the wrap bit
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  // Read data straight from storage; the consumer registers it
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  // Write side
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Storage has no reset; empty flag hides stale words
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  // Read side
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule : fsp_fifo

`default_nettype wire

// *** fsp_serial_port.sv ***
/*
  Device end of the framed serial sample port: sources the shift clock,
  sends buffered result words each behind their own frame sync, and
  receives framed control words from the host.
  Assumes the host samples on the falling shift clock edge, changes its
  data on the rising one, and that its inputs arrive asynchronous to clk_i.
*/
`default_nettype none

module fsp_serial_port
  import fsp_pkg::*;
#(
  parameter int DIV = FSP_SCLK_DIV,
  parameter int DEPTH = FSP_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic result_valid_i,
  output logic result_ready_o,
  input wire logic [FSP_WORD_BITS-1:0] result_data_i,
  output logic result_pending_o,
  output logic serial_shift_clock_o,
  output logic serial_result_out_o,
  output logic result_frame_sync_out_o,
  input wire logic serial_control_in_i,
  input wire logic control_frame_sync_in_i,
  output logic [FSP_WORD_BITS-1:0] ctrl_word_o,
  output logic ctrl_valid_o
);

  localparam int CW = $clog2(DIV);
  localparam int BW = $clog2(FSP_WORD_BITS);

  logic [CW-1:0] div_cnt;  // Shift clock phase
  logic tick;  // Last phase before a rising shift clock edge
  logic sample_pt;  // Phase for sampling host pins
  logic fifo_valid;  // Buffered word ready
  logic [FSP_WORD_BITS-1:0] fifo_data;  // Head of buffer
  logic tx_pop;  // Take the head word
  fsp_tx_state_t tx_state;  // Transmit sequencer
  logic [FSP_WORD_BITS-1:0] tx_word;  // Word being sent, kept whole
  logic [FSP_WORD_BITS-1:0] tx_shreg;  // Remaining bits
  logic [BW-1:0] tx_bits;  // Bits still to send after current
  logic tx_last;  // Current bit is the LSB
  logic [1:0] din_sync;  // Control data synchroniser
  logic [1:0] fs_sync;  // Control frame sync synchroniser
  logic rx_active;  // Receiving a control word
  logic [BW-1:0] rx_cnt;  // Bits received so far
  logic [FSP_WORD_BITS-1:0] rx_shreg;  // Assembling control word

  // Result buffer; its ready stalls the user side
  fsp_fifo #(
    .WIDTH(FSP_WORD_BITS),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(result_valid_i),
    .in_ready_o(result_ready_o),
    .in_data_i(result_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(tx_pop),
    .out_data_o(fifo_data)
  );

  assign tick = (div_cnt == CW'(DIV - 1));
  assign sample_pt = (div_cnt == CW'(FSP_SAMPLE_PHASE));
  assign tx_last = (tx_state == FSP_TX_SHIFT) && (tx_bits == '0);
  // A new frame may start straight after the previous LSB, so words stream back to back
  assign tx_pop = tick && fifo_valid && ((tx_state == FSP_TX_IDLE) || tx_last);
  // Tells the host a result is still queued or on the wire
  assign result_pending_o = fifo_valid || (tx_state != FSP_TX_IDLE);

  // Shift clock divider, free running so the host always has a clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= '0;
    end else if (tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // Shift clock output, high for the first half of each period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_shift_clock_o <= 1'b0;
    end else if (tick) begin
      serial_shift_clock_o <= 1'b1;
    end else if (div_cnt == CW'(FSP_SCLK_HALF - 1)) begin
      serial_shift_clock_o <= 1'b0;
    end
  end

  // Transmit sequencer: idle, one sync period, sixteen bit periods
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state <= FSP_TX_IDLE;
    end else if (tick) begin
      case (tx_state)
        FSP_TX_IDLE: begin
          if (tx_pop) begin
            tx_state <= FSP_TX_SYNC;
          end
        end
        FSP_TX_SYNC: begin
          tx_state <= FSP_TX_SHIFT;
        end
        FSP_TX_SHIFT: begin
          if (tx_last) begin
            tx_state <= tx_pop ? FSP_TX_SYNC : FSP_TX_IDLE;
          end
        end
        default: begin
          tx_state <= FSP_TX_IDLE;
        end
      endcase
    end
  end

  // Result frame sync, high only in the period before the MSB
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_frame_sync_out_o <= 1'b0;
    end else if (tick) begin
      result_frame_sync_out_o <= tx_pop;
    end
  end

  // Word capture and shift register; MSB goes out first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_word <= '0;
      tx_shreg <= '0;
      tx_bits <= '0;
      serial_result_out_o <= 1'b0;
    end else if (tick) begin
      if (tx_pop) begin
        tx_word <= fifo_data;
        serial_result_out_o <= 1'b0;
      end else if (tx_state == FSP_TX_SYNC) begin
        serial_result_out_o <= tx_word[FSP_WORD_BITS-1];
        tx_shreg <= {tx_word[FSP_WORD_BITS-2:0], 1'b0};
        tx_bits <= BW'(FSP_WORD_BITS - 1);
      end else if (tx_state == FSP_TX_SHIFT && !tx_last) begin
        serial_result_out_o <= tx_shreg[FSP_WORD_BITS-1];
        tx_shreg <= {tx_shreg[FSP_WORD_BITS-2:0], 1'b0};
        tx_bits <= tx_bits - 1'b1;
      end else begin
        // Line rests low between words
        serial_result_out_o <= 1'b0;
      end
    end
  end

  // Two-stage synchronisers for host-driven pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      din_sync <= 2'h0;
      fs_sync <= 2'h0;
    end else begin
      din_sync <= {din_sync[0], serial_control_in_i};
      fs_sync <= {fs_sync[0], control_frame_sync_in_i};
    end
  end

  // Control word receiver; a sync seen while busy is ignored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_active <= 1'b0;
      rx_cnt <= '0;
      rx_shreg <= '0;
    end else if (sample_pt) begin
      if (!rx_active) begin
        if (fs_sync[1]) begin
          rx_active <= 1'b1;
          rx_cnt <= '0;
        end
      end else begin
        rx_shreg <= {rx_shreg[FSP_WORD_BITS-2:0], din_sync[1]};
        rx_cnt <= rx_cnt + 1'b1;
        if (rx_cnt == BW'(FSP_WORD_BITS - 1)) begin
          rx_active <= 1'b0;
        end
      end
    end
  end

  // Completed control word and its one-cycle strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_word_o <= '0;
      ctrl_valid_o <= 1'b0;
    end else if (sample_pt && rx_active && rx_cnt == BW'(FSP_WORD_BITS - 1)) begin
      ctrl_word_o <= {rx_shreg[FSP_WORD_BITS-2:0], din_sync[1]};
      ctrl_valid_o <= 1'b1;
    end else begin
      ctrl_valid_o <= 1'b0;
    end
  end

  // Shift clock high phase lasts exactly half a period
  property p_sclk_high;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(serial_shift_clock_o) |-> serial_shift_clock_o[*4] ##1 !serial_shift_clock_o;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("shift clock high phase wrong");

  // Frame sync lasts one full shift clock period
  property p_fs_width;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(result_frame_sync_out_o) |-> result_frame_sync_out_o[*8] ##1 !result_frame_sync_out_o;
  endproperty
  a_fs_width: assert property (p_fs_width) else $error("frame sync width wrong");

  // Sync high only while in the sync state
  property p_fs_state;
    @(posedge clk_i) disable iff (!rst_n_i)
    result_frame_sync_out_o |-> tx_state == FSP_TX_SYNC;
  endproperty
  a_fs_state: assert property (p_fs_state) else $error("frame sync outside sync period");

  // Every frame is caused by taking one word from the buffer
  property p_fs_pop;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(result_frame_sync_out_o) |-> $past(tx_pop);
  endproperty
  a_fs_pop: assert property (p_fs_pop) else $error("frame without a word");

  // The shifting period lasts sixteen bit periods exactly
  property p_word_len;
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(result_frame_sync_out_o) |-> ##127 tx_state == FSP_TX_SHIFT ##1 tx_state != FSP_TX_SHIFT;
  endproperty
  a_word_len: assert property (p_word_len) else $error("word not sixteen bits");

  // MSB is on the line as the sync drops, and data moves with the clock rise
  property p_msb_first;
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(result_frame_sync_out_o) |-> serial_result_out_o == tx_word[FSP_WORD_BITS-1] && $rose(serial_shift_clock_o);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("MSB not first after sync");

  // Receiver takes sixteen sample periods then strobes the word
  property p_rx_len;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(rx_active) |-> ##127 rx_active ##1 (!rx_active && ctrl_valid_o);
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("control word length wrong");

  // Control strobe is a single cycle
  property p_ctrl_pulse;
    @(posedge clk_i) disable iff (!rst_n_i)
    ctrl_valid_o |=> !ctrl_valid_o;
  endproperty
  a_ctrl_pulse: assert property (p_ctrl_pulse) else $error("control strobe too long");

endmodule : fsp_serial_port

`default_nettype wire

// *** fsp_host_model.sv ***
/* Host serial port model: takes shift clock and result sync from the device,
   transmit sync looped back from the result sync.
   Assumes the bench wires both syncs to the device's result sync. */
`default_nettype none

module fsp_host_model (
  input wire logic sclk_i, // Shift clock, only ever received
  input wire logic rst_n_i,
  input wire logic data_i,
  input wire logic rx_sync_i,
  input wire logic tx_sync_i,
  output var logic data_o,
  output var logic [15:0] rx_word_o,
  output var int rx_count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int rx_left; // Bits still to take in
  int tx_left; // Bits still to send
  int tx_n; // Words sent so far
  int tx_req; // Syncs taken at falling edges, written there only
  int tx_ack; // Syncs acted on at rising edges, written there only
  logic [15:0] rx_sh; // Receive shifter
  logic [15:0] tx_sh; // Transmit shifter

  // Sample on the falling edge, where the device data is settled
  always @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_left = 0;
      rx_count_o = 0;
      tx_req = 0;
    end else begin
      // A request counter instead of a shared flag keeps one writer per variable
      if (tx_sync_i && tx_left == 0 && tx_req == tx_ack) begin
        tx_req++;
      end
      if (rx_left > 0) begin
        rx_sh = {rx_sh[14:0], data_i};
        rx_left--;
        if (rx_left == 0) begin
          rx_word_o = rx_sh;
          rx_count_o++;
        end
      end else if (rx_sync_i) begin
        rx_left = 16;
      end
    end
  end

  // Drive on the rising edge; each word starts at the rise after its sync
  always @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_left = 0;
      tx_n = 0;
      tx_ack = 0;
      data_o <= 1'b0;
    end else if (tx_req != tx_ack) begin
      tx_ack = tx_req;
      tx_sh = 16'hc35a ^ {tx_n[7:0], tx_n[7:0]};
      tx_n++;
      data_o <= tx_sh[15];
      tx_left = 15;
    end else if (tx_left > 0) begin
      tx_sh = {tx_sh[14:0], 1'b0};
      data_o <= tx_sh[15];
      tx_left--;
    end else begin
      // Released line toggles so a stale bit can never pass as data
      data_o <= ~data_o;
    end
  end
endmodule : fsp_host_model

`default_nettype wire

// *** fsp_serial_port_tb.sv ***
/* Bench for the framed serial sample port: host model in loop-back wiring,
   result words pushed through the buffer, frames watched on the wire.
   Assumes package defaults: 8 clocks per shift period, 4-word buffer. */
`default_nettype none

module fsp_serial_port_tb
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0; // 25 MHz system clock
  logic rst_n_i; // Reset, active low; driven low at time 0 so every reset branch sees an edge
  logic result_valid_i = 1'b0;
  logic [FSP_WORD_BITS-1:0] result_data_i = 16'h0000;
  logic result_ready_o, result_pending_o, sclk, serial_result_out, fs, ctrl_valid_o, host_data;
  logic [FSP_WORD_BITS-1:0] ctrl_word_o, rx_word;
  logic sclk_d = 1'b0, fs_d = 1'b0, saw_full = 1'b0; // Edge history, buffer refusal seen
  int rx_count, n_mismatch = 0, samples_checked = 0, n_ctrl = 0, n_frames = 0, rx_seen = 0;
  // Host sample period, 16 kSPS: its period holds six words, twice the rate's does not
  localparam int SAMPLE_NS = 62500;
  int fs_len = 0, cyc = 0, last_rise = 0, last_gap = 0, n_sclk = 0;

  always #20 clk_i = ~clk_i;

  fsp_serial_port fsp_serial_port_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .result_valid_i(result_valid_i), .result_ready_o(result_ready_o), .result_data_i(result_data_i),
    .result_pending_o(result_pending_o), .serial_shift_clock_o(sclk), .serial_result_out_o(serial_result_out),
    .result_frame_sync_out_o(fs), .serial_control_in_i(host_data), .control_frame_sync_in_i(fs),
    .ctrl_word_o(ctrl_word_o), .ctrl_valid_o(ctrl_valid_o));
  // Loop-back wiring: both host syncs come from the result sync
  fsp_host_model fsp_host_model_inst (.sclk_i(sclk), .rst_n_i(rst_n_i), .data_i(serial_result_out), .rx_sync_i(fs),
    .tx_sync_i(fs), .data_o(host_data), .rx_word_o(rx_word), .rx_count_o(rx_count));

  // Result word k; top and bottom bits set to catch bit order slips
  function automatic logic [15:0] res_word(input int k);
    return 16'h8001 ^ {k[3:0], 4'h0, k[3:0], 4'h0};
  endfunction : res_word

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Wire monitor: sync alignment, length, spacing and control words
  always @(posedge clk_i) begin
    cyc++;
    sclk_d <= sclk;
    fs_d <= fs;
    if (sclk && !sclk_d) n_sclk++;
    if (fs && !fs_d) begin
      check("sync on shift clock rise", {15'h0000, sclk && !sclk_d}, 16'h0001);
      last_gap = cyc - last_rise;
      last_rise = cyc;
      n_frames++;
    end
    if (fs) fs_len++;
    else begin
      if (fs_d === 1'b1) check("sync length", fs_len[15:0], 16'h0008);
      fs_len = 0;
    end
    if (ctrl_valid_o === 1'b1) begin
      check("control word", ctrl_word_o, 16'hc35a ^ {n_ctrl[7:0], n_ctrl[7:0]});
      n_ctrl++;
    end
    // Every word the host takes in must match what was pushed, in order; looked at one edge later
    if (rx_count > rx_seen) begin
      check("result word", rx_word, res_word(rx_seen));
      rx_seen++;
    end
  end

  // Hold valid up; a refused word is held until taken
  task automatic push_words(input int first, input int n);
    int i;
    int t;
    i = 0;
    t = 0;
    result_valid_i <= 1'b1;
    result_data_i <= res_word(first);
    while (i < n && t < 3000) begin
      @(posedge clk_i);
      t++;
      if (result_ready_o === 1'b1) i++;
      else saw_full = 1'b1;
      if (i < n) result_data_i <= res_word(first + i);
    end
    // A limit that runs out counts as a mismatch
    if (i < n) n_mismatch++;
    result_valid_i <= 1'b0;
  endtask : push_words

  // Bounded wait for n words each way, then one shift period for the LSB
  task automatic wait_done(input int n);
    int t;
    t = 0;
    while ((rx_count < n || n_ctrl < n) && t < 3000) begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 3000) n_mismatch++;
    repeat (8) @(posedge clk_i);
  endtask : wait_done

  // One word alone: one frame, payload and looped-back control word
  task automatic s_single();
    push_words(0, 1);
    wait_done(1);
    check("pending after drain", {15'h0000, result_pending_o}, 16'h0000);
    check("frames", n_frames[15:0], 16'h0001);
    check("shift clock running", {15'h0000, n_sclk > 10}, 16'h0001);
  endtask : s_single

  // Six words back to back: buffer refuses when full, frames abut
  task automatic s_burst();
    push_words(1, 6);
    wait_done(7);
    check("buffer refused when full", {15'h0000, saw_full}, 16'h0001);
    check("back to back spacing", last_gap[15:0], 16'h0088);
    // Six abutting words must fit the chosen sample period
    check("readout fits", {15'h0000, 6 * last_gap * FSP_CLK_PERIOD_NS <= SAMPLE_NS}, 16'h0001);
    // At the 320 ns shift clock, twice the rate no longer holds six words
    check("double rate", {15'h0000, 6 * last_gap * FSP_CLK_PERIOD_NS > SAMPLE_NS / 2}, 16'h0001);
    check("frames", n_frames[15:0], 16'h0007);
    check("pending after drain", {15'h0000, result_pending_o}, 16'h0000);
  endtask : s_burst

  // Idle link: no frame and no control word without a pushed word
  task automatic s_idle();
    repeat (400) @(posedge clk_i);
    check("idle frames", n_frames[15:0], 16'h0007);
    check("idle control words", n_ctrl[15:0], 16'h0007);
  endtask : s_idle

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  // Main sequence: reset for 4 cycles, then the scenarios
  initial begin
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    s_single();
    s_burst();
    s_idle();
    close_out();
  end

  // Watchdog: the run needs about 1400 cycles, this allows 10000
  initial begin
    #400us;
    n_mismatch++;
    close_out();
  end
endmodule : fsp_serial_port_tb

`default_nettype wire
